// ### lbm_bucket.sv
// Leaky-bucket accumulator and alarm hysteresis
`timescale 1ns/1ns
`default_nettype none
module lbm_bucket (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic tick_i,
    input wire logic fault_i,
    input wire lbm_pkg::lbm_cfg_t cfg_i,
    output logic [7:0] level_o,
    output logic alarm_o,
    output lbm_pkg::lbm_evt_t evt_o
);
    typedef struct packed {
        logic [7:0] level;
        logic [3:0] clean_cnt;
        logic alarm;
        lbm_pkg::lbm_evt_t evt;
    } lbm_bucket_st_t;

    lbm_bucket_st_t st;
    lbm_bucket_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.evt = '0;
        if (tick_i) begin
            if (fault_i) begin
                next_st.level = lbm_pkg::sat_inc(st.level);
                next_st.clean_cnt = 4'h0;
            end else if (st.clean_cnt + 4'h1 >= lbm_pkg::drain_len(cfg_i.drain_sel)) begin
                next_st.level = lbm_pkg::sat_dec(st.level);
                next_st.clean_cnt = 4'h0;
            end else begin
                next_st.clean_cnt = st.clean_cnt + 4'h1;
            end
        end
        // Limits may be rewritten at any time, so compare every cycle
        if (!st.alarm && next_st.level >= cfg_i.set_limit) begin
            next_st.alarm = 1'b1;
            next_st.evt.raise = 1'b1;
        end else if (st.alarm && next_st.level <= cfg_i.clear_limit) begin
            next_st.alarm = 1'b0;
            next_st.evt.clear = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.level;
    assign alarm_o = st.alarm;
    assign evt_o = st.evt;
endmodule
`default_nettype wire

// ### lbm_irq.sv
// Sticky event status with write-one-to-clear; the mask is applied in the top
`timescale 1ns/1ns
`default_nettype none
module lbm_irq (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire lbm_pkg::lbm_evt_t evt_i,
    input wire logic [1:0] w1c_i,
    output logic [1:0] status_o
);
    typedef struct packed {
        logic [1:0] status;
    } lbm_irq_st_t;

    lbm_irq_st_t st;
    lbm_irq_st_t next_st;

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        next_st = st;
        next_st.status = (st.status & ~w1c_i) | {evt_i.clear, evt_i.raise};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status_o = st.status;
endmodule
`default_nettype wire

// ### lbm_pkg.sv
// Constants, types and helpers for the leaky-bucket activity monitor
// Summary of operation
// - Set-limit register, 8 bits read/write, resets to 0x06, raises the alarm.
// - Clear-limit register, 8 bits read/write, resets to 0x04, clears the alarm.
// - Each monitoring cycle with a failed or erratic input adds one to the bucket.
// - Each clean run of 1, 2, 4 or 8 cycles removes one from the bucket.
// - Bucket reaching the set limit raises the activity alarm.
`default_nettype none
package lbm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SET_LIMIT = 8'h5C;
    localparam logic [7:0] IDX_CLEAR_LIMIT = 8'h5D;
    localparam logic [7:0] IDX_DRAIN_PERIOD = 8'h5F;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
    localparam logic [7:0] IDX_BUCKET_STATE = 8'h62;

    // Reset values
    localparam logic [7:0] RST_SET_LIMIT = 8'h06;
    localparam logic [7:0] RST_CLEAR_LIMIT = 8'h04;
    localparam logic [1:0] RST_DRAIN_PERIOD = 2'h0;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;

    // Field positions
    localparam int EVT_RAISE_BIT = 0;
    localparam int EVT_CLEAR_BIT = 1;
    localparam int STATE_ALARM_BIT = 8;

    localparam logic [7:0] LEVEL_MAX = 8'hFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] set_limit;
        logic [7:0] clear_limit;
        logic [1:0] drain_sel;
    } lbm_cfg_t;

    typedef struct packed {
        logic raise;
        logic clear;
    } lbm_evt_t;

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == LEVEL_MAX) ? v : v + 8'h01;
    endfunction

    function automatic logic [7:0] sat_dec(input logic [7:0] v);
        sat_dec = (v == 8'h00) ? v : v - 8'h01;
    endfunction

    // Clean cycles per drain step: 1, 2, 4 or 8
    function automatic logic [3:0] drain_len(input logic [1:0] sel);
        drain_len = 4'h1 << sel;
    endfunction

endpackage
`default_nettype wire

// ### lbm_top.sv
// Activity monitor top: AHB-Lite register slave, fault capture, bucket and interrupt
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module lbm_top (
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic CYCLE_TICK_I,
    input wire logic FAULT_I,
    output logic ALARM_O,
    output logic IRQ_O
);
    typedef struct packed {
        lbm_pkg::lbm_cfg_t cfg;
        logic [1:0] mask;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic fault_seen;
        logic [31:0] rdata;
        logic readyout;
        logic alarm;
        logic irq;
    } lbm_top_st_t;

    lbm_top_st_t st;
    lbm_top_st_t next_st;

    logic [7:0] level;
    logic alarm_core;
    lbm_pkg::lbm_evt_t evt;
    logic [1:0] status;
    logic [1:0] w1c;
    logic addr_phase;
    logic [7:0] addr_idx;

    assign addr_phase = HSEL_I && HREADY_I && (HTRANS_I == lbm_pkg::HTRANS_NONSEQ);
    assign addr_idx = HADDR_I[9:2];
    assign w1c = (st.wr_pend && st.wr_idx == lbm_pkg::IDX_IRQ_STATUS) ? HWDATA_I[1:0] : 2'h0;

    always_comb begin
        next_st = st;
        next_st.readyout = 1'b1;
        // Data phase of a write: registers take hwdata now
        if (st.wr_pend) begin
            case (st.wr_idx)
                lbm_pkg::IDX_SET_LIMIT: begin
                    next_st.cfg.set_limit = HWDATA_I[7:0];
                end
                lbm_pkg::IDX_CLEAR_LIMIT: begin
                    next_st.cfg.clear_limit = HWDATA_I[7:0];
                end
                lbm_pkg::IDX_DRAIN_PERIOD: begin
                    next_st.cfg.drain_sel = HWDATA_I[1:0];
                end
                lbm_pkg::IDX_IRQ_MASK: begin
                    next_st.mask = HWDATA_I[1:0];
                end
                default: begin
                    next_st.mask = next_st.mask;
                end
            endcase
        end
        next_st.wr_pend = addr_phase && HWRITE_I;
        next_st.wr_idx = addr_idx;
        // Limit, drain and mask read data built from the post-write values, so a read right after a write sees it; IRQ status reads the current value
        next_st.rdata = 32'h0000_0000;
        if (addr_phase && !HWRITE_I) begin
            case (addr_idx)
                lbm_pkg::IDX_SET_LIMIT: begin
                    next_st.rdata[7:0] = next_st.cfg.set_limit;
                end
                lbm_pkg::IDX_CLEAR_LIMIT: begin
                    next_st.rdata[7:0] = next_st.cfg.clear_limit;
                end
                lbm_pkg::IDX_DRAIN_PERIOD: begin
                    next_st.rdata[1:0] = next_st.cfg.drain_sel;
                end
                lbm_pkg::IDX_IRQ_STATUS: begin
                    next_st.rdata[1:0] = status;
                end
                lbm_pkg::IDX_IRQ_MASK: begin
                    next_st.rdata[1:0] = next_st.mask;
                end
                lbm_pkg::IDX_BUCKET_STATE: begin
                    next_st.rdata[7:0] = level;
                    next_st.rdata[lbm_pkg::STATE_ALARM_BIT] = alarm_core;
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Fault seen at any time in the cycle, including the tick cycle itself
        if (CYCLE_TICK_I) begin
            next_st.fault_seen = 1'b0;
        end else if (FAULT_I) begin
            next_st.fault_seen = 1'b1;
        end
        next_st.alarm = alarm_core;
        next_st.irq = |(status & st.mask);
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st <= '0;
            st.cfg.set_limit <= lbm_pkg::RST_SET_LIMIT;
            st.cfg.clear_limit <= lbm_pkg::RST_CLEAR_LIMIT;
            st.cfg.drain_sel <= lbm_pkg::RST_DRAIN_PERIOD;
            st.mask <= lbm_pkg::RST_IRQ_MASK;
            st.readyout <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    lbm_bucket u_bucket (
        .clk_i(CLOCK_I),
        .arst_n_i(ARST_N_I),
        .tick_i(CYCLE_TICK_I),
        .fault_i(st.fault_seen | FAULT_I),
        .cfg_i(st.cfg),
        .level_o(level),
        .alarm_o(alarm_core),
        .evt_o(evt)
    );

    lbm_irq u_irq (
        .clk_i(CLOCK_I),
        .arst_n_i(ARST_N_I),
        .evt_i(evt),
        .w1c_i(w1c),
        .status_o(status)
    );

    // Zero-wait slave: never stalls, always OKAY
    assign HRDATA_O = st.rdata;
    assign HREADYOUT_O = st.readyout;
    assign HRESP_O = 1'b0;
    assign ALARM_O = st.alarm;
    assign IRQ_O = st.irq;
endmodule
`default_nettype wire

// ### lbm_top_sva.sv
// Port assertions for the activity monitor top
`timescale 1ns/1ns
`default_nettype none
module lbm_top_sva (
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic CYCLE_TICK_I,
    input wire logic FAULT_I,
    input wire logic ALARM_O,
    input wire logic IRQ_O
);
    // No alarm can rise before any fault was ever seen
    logic seen_fault;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            seen_fault <= 1'b0;
        end else if (FAULT_I) begin
            seen_fault <= 1'b1;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);
    AST_BUS_OKAY: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus answer not ready or not okay");
    AST_RD_IDLE: assert property (!$past(HSEL_I && HREADY_I && HTRANS_I == 2'h2 && !HWRITE_I)
        |-> HRDATA_O == 32'h0000_0000) else $error("read data outside data phase");
    AST_RD_UPPER: assert property (HRDATA_O[31:9] == 23'h0)
        else $error("read data upper bits set");
    AST_RISE_TICK: assert property ($rose(ALARM_O)
        |-> $past(CYCLE_TICK_I) || $past(CYCLE_TICK_I, 2) || $past(CYCLE_TICK_I, 3))
        else $error("alarm rose without a tick");
    AST_FALL_TICK: assert property ($fell(ALARM_O)
        |-> $past(CYCLE_TICK_I) || $past(CYCLE_TICK_I, 2) || $past(CYCLE_TICK_I, 3))
        else $error("alarm fell without a tick");
    AST_RISE_FAULT: assert property ($rose(ALARM_O) |-> seen_fault)
        else $error("alarm rose with no fault");
    cover property ($rose(ALARM_O));
    cover property ($fell(ALARM_O));
    cover property ($rose(IRQ_O));
endmodule
bind lbm_top lbm_top_sva i_lbm_top_sva (.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .CYCLE_TICK_I(CYCLE_TICK_I),
    .FAULT_I(FAULT_I), .ALARM_O(ALARM_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the activity monitor top
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic tck = 1'b0;
    logic flt = 1'b0;
    logic [1:0] trans = 2'h0;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, hr_s, d;
    logic rdy, resp, alarm, irq;
    logic [7:0] lvl;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    // Read data captured at the edge so the task never races the slave
    always @(posedge clk) hr_s <= rdata;
    lbm_top i_lbm_top (.CLOCK_I(clk), .ARST_N_I(rst_n), .HSEL_I(sel), .HADDR_I(addr),
        .HTRANS_I(trans), .HWRITE_I(wr), .HSIZE_I(3'h2), .HWDATA_I(wdata), .HREADY_I(rdy),
        .HRDATA_O(rdata), .HREADYOUT_O(rdy), .HRESP_O(resp), .CYCLE_TICK_I(tck),
        .FAULT_I(flt), .ALARM_O(alarm), .IRQ_O(irq));
    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] v);
        @(posedge clk);
        sel <= 1'b1;
        trans <= lbm_pkg::HTRANS_NONSEQ;
        wr <= w;
        addr <= {22'h0, idx, 2'h0};
        do @(posedge clk); while (rdy !== 1'b1);
        sel <= 1'b0;
        trans <= 2'h0;
        wdata <= v;
        do @(posedge clk); while (rdy !== 1'b1);
        @(negedge clk);
        d = hr_s;
    endtask
    task automatic chk_reg(input logic [7:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0000_0000);
        n_compared++;
        if (d !== e) begin
            fails++;
            $display("wrong value at %0t: reg %h got %h exp %h", $time, idx, d, e);
        end
    endtask
    task automatic chk_pin(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: pin got %b exp %b", $time, g, e);
        end
    endtask
    task automatic tick(input logic f, input int n);
        repeat (n) begin
            @(posedge clk);
            tck <= 1'b1;
            flt <= f;
            @(posedge clk);
            tck <= 1'b0;
            flt <= 1'b0;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(lbm_pkg::IDX_SET_LIMIT, 32'h0000_0006);
        chk_reg(lbm_pkg::IDX_CLEAR_LIMIT, 32'h0000_0004);
        chk_reg(8'h3F, 32'h0000_0000);
        chk_pin(resp, 1'b0);
        chk_pin(rdy, 1'b1);
        $display("test reset values done");
        xfer(1'b1, lbm_pkg::IDX_SET_LIMIT, 32'hFFFF_FFA5);
        chk_reg(lbm_pkg::IDX_SET_LIMIT, 32'h0000_00A5);
        xfer(1'b1, lbm_pkg::IDX_CLEAR_LIMIT, 32'h1234_565A);
        chk_reg(lbm_pkg::IDX_CLEAR_LIMIT, 32'h0000_005A);
        xfer(1'b1, lbm_pkg::IDX_SET_LIMIT, 32'h0000_0006);
        xfer(1'b1, lbm_pkg::IDX_CLEAR_LIMIT, 32'h0000_0004);
        xfer(1'b1, lbm_pkg::IDX_IRQ_MASK, 32'h0000_0003);
        $display("test limit registers done");
        tick(1'b1, 5);
        chk_reg(lbm_pkg::IDX_BUCKET_STATE, 32'h0000_0005);
        chk_pin(alarm, 1'b0);
        tick(1'b1, 1);
        chk_reg(lbm_pkg::IDX_BUCKET_STATE, 32'h0000_0106);
        chk_pin(alarm, 1'b1);
        chk_pin(irq, 1'b1);
        xfer(1'b1, lbm_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        chk_reg(lbm_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
        chk_pin(irq, 1'b0);
        $display("test fill and alarm done");
        // Each drain period: one short of the run keeps the level, the full run drops it
        lvl = 8'h06;
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, lbm_pkg::IDX_DRAIN_PERIOD, 32'(s));
            tick(1'b0, (1 << s) - 1);
            chk_reg(lbm_pkg::IDX_BUCKET_STATE, {23'h0, lvl > 8'h04, lvl});
            tick(1'b0, 1);
            lvl--;
            chk_reg(lbm_pkg::IDX_BUCKET_STATE, {23'h0, lvl > 8'h04, lvl});
            chk_pin(alarm, lvl > 8'h04);
        end
        chk_reg(lbm_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
        chk_pin(irq, 1'b1);
        $display("test drain periods done");
        xfer(1'b1, lbm_pkg::IDX_DRAIN_PERIOD, 32'h0000_0000);
        tick(1'b0, 3);
        chk_reg(lbm_pkg::IDX_BUCKET_STATE, 32'h0000_0000);
        tick(1'b1, 256);
        chk_reg(lbm_pkg::IDX_BUCKET_STATE, 32'h0000_01FF);
        xfer(1'b1, lbm_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        chk_reg(lbm_pkg::IDX_IRQ_STATUS, 32'h0000_0003);
        chk_pin(irq, 1'b0);
        xfer(1'b1, lbm_pkg::IDX_IRQ_STATUS, 32'h0000_0003);
        xfer(1'b1, lbm_pkg::IDX_IRQ_MASK, 32'h0000_0003);
        chk_reg(lbm_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
        chk_pin(irq, 1'b0);
        $display("test saturation and masking done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
